// ===== verilog/usb_err_consts.svh
// offsets, field positions, reset values and timing counts of the usb error/endpoint/vbus block
`ifndef USB_ERR_CONSTS_SVH
`define USB_ERR_CONSTS_SVH
`define ADDR_ERR_FLAGS 8'h00
`define ADDR_ERR_ENABLES 8'h01
`define ADDR_PWM_CTRL 8'h02
`define ADDR_MODE_CTRL 8'h03
`define ADDR_EP_BASE 8'h10
`define ERR_STUFF_BIT 7
`define ERR_OVERRUN_BIT 5
`define ERR_TURN_BIT 4
`define ERR_PARTIAL_BIT 3
`define ERR_DCRC_BIT 2
`define ERR_TCRC_BIT 1
`define ERR_PID_BIT 0
`define ERR_IMPL_MASK 16'h00BF
`define EP_LOWSPD_BIT 7
`define EP_RETRYOFF_BIT 6
`define EP_SETUPBLK_BIT 4
`define EP_RX_BIT 3
`define EP_TX_BIT 2
`define EP_STALL_BIT 1
`define EP_HSHK_BIT 0
`define EP0_IMPL_MASK 8'hDF
`define EPN_IMPL_MASK 8'h1F
`define PWM_EN_BIT 15
`define PWM_POL_BIT 9
`define PWM_CNT_BIT 8
`define PWM_IMPL_MASK 16'h8300
`define MODE_HOST_BIT 0
`define RESET_WORD 16'h0000
`define CLK_MHZ 50
`define TURN_LIMIT_NS 1500
`define TURN_CYCLES ((`TURN_LIMIT_NS * `CLK_MHZ) / 1000)
`define CRC16_INIT 16'hFFFF
`define CRC16_POLY 16'hA001
`define CRC16_GOOD 16'hB001
`define CRC5_INIT 5'h1F
`define CRC5_POLY 5'h14
`define CRC5_GOOD 5'h06
`endif

// ===== verilog/usb_err_pkg.sv
// types shared by the usb error/endpoint/vbus block
package usb_err_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_PID = 2'b01,
    RX_BODY = 2'b10
  } rx_state_type;
  typedef logic [15:0] reg_word_type;
endpackage : usb_err_pkg

// ===== verilog/crc_feed_if.sv
// byte stream into the crc checker and its running remainders
`timescale 1ns/1ps
interface crc_feed_if;
  logic clear;
  logic byte_valid;
  logic [7:0] data;
  logic [15:0] crc16;
  logic [4:0] crc5;
  modport engine (output clear, output byte_valid, output data, input crc16, input crc5);
  modport crc_side (input clear, input byte_valid, input data, output crc16, output crc5);
endinterface : crc_feed_if

// ===== verilog/usb_crc_checker.sv
// running crc16 and crc5 remainders over received bytes, lsb first
`timescale 1ns/1ps
`include "usb_err_consts.svh"
module usb_crc_checker
  import usb_err_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  crc_feed_if.crc_side feed
);
  logic [15:0] crc16_reg;
  logic [4:0] crc5_reg;
  logic [15:0] crc16_next;
  logic [4:0] crc5_next;

  always_comb begin
    crc16_next = crc16_reg;
    crc5_next = crc5_reg;
    for (int i = 0; i < 8; i++) begin
      if (crc16_next[0] ^ feed.data[i]) begin
        crc16_next = (crc16_next >> 1) ^ `CRC16_POLY;
      end else begin
        crc16_next = crc16_next >> 1;
      end
      if (crc5_next[0] ^ feed.data[i]) begin
        crc5_next = (crc5_next >> 1) ^ `CRC5_POLY;
      end else begin
        crc5_next = crc5_next >> 1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc16_reg <= `CRC16_INIT;
      crc5_reg <= `CRC5_INIT;
    end else if (feed.clear) begin
      crc16_reg <= `CRC16_INIT;
      crc5_reg <= `CRC5_INIT;
    end else if (feed.byte_valid) begin
      crc16_reg <= crc16_next;
      crc5_reg <= crc5_next;
    end
  end

  assign feed.crc16 = crc16_reg;
  assign feed.crc5 = crc5_reg;
endmodule : usb_crc_checker

// ===== verilog/usb_error_endpoint_vbus_ctrl.sv
// usb error flags, endpoint control registers and vbus pwm control bits
`timescale 1ns/1ps
`include "usb_err_consts.svh"
// Behaviour
// - bit stuff violation sets flag bit 7
// - excess bytes truncated, overrun flag bit 5
// - missing response within turnaround sets bit 4
// - non-integral byte data field sets bit 3
// - failed data crc16 sets bit 2
// - device mode: bad token crc5 rejected, bit 1
// - host mode: bit 1 reports end-of-frame error
// - failed packet id check sets bit 0
// - flags clear only by writing one
// - bits 15-8 and 6 read zero
// - enable bit 1 follows mode meaning
// - summary error when enabled flag set
// - endpoint 0 host: bit 6 stops nak retry
// - retry/low-speed bits only on endpoint 0
// - both directions on: bit 4 blocks setup
// - setup block ignored unless both directions
// - bit 3 receive, bit 2 transmit enable
// - bit 1 shows endpoint was stalled
// - pwm disabled holds polarity reset level
// - polarity bit 9 selects active level
// - bit 8 runs or halts pwm counter
module usb_error_endpoint_vbus_ctrl
  import usb_err_pkg::*;
#(
  parameter int NUM_EP = 16,
  parameter int BYTE_COUNT_W = 10
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_pkt_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eop,
  input wire logic [2:0] rx_bit_rem,
  input wire logic stuff_violation,
  input wire logic frame_end_violation,
  input wire logic [BYTE_COUNT_W-1:0] bd_byte_count,
  input wire logic resp_wait_start,
  input wire logic resp_arrived,
  input wire logic [NUM_EP-1:0] ep_stall_event,
  input wire logic pwm_raw,
  output logic store_valid,
  output logic [7:0] store_data,
  output logic token_accept,
  output logic summary_error_irq_flag,
  output logic host_mode,
  output logic [NUM_EP-1:0] ep_receive_active,
  output logic [NUM_EP-1:0] ep_transmit_active,
  output logic [NUM_EP-1:0] ep_setup_allowed,
  output logic [NUM_EP-1:0] ep_handshake_active,
  output logic nak_retry_auto,
  output logic low_speed_direct,
  output logic vbus_pwm_out,
  output logic vbus_counter_run
);
  localparam int TURN_CYCLES = `TURN_CYCLES;

  if (NUM_EP < 1 || NUM_EP > 16) begin : g_bad_ep
    $error("NUM_EP must be 1 to 16");
  end
  if (BYTE_COUNT_W < 1 || BYTE_COUNT_W > 16) begin : g_bad_bc
    $error("BYTE_COUNT_W must be 1 to 16");
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  reg_word_type err_flags_reg;
  reg_word_type err_enables_reg;
  reg_word_type pwm_ctrl_reg;
  logic mode_reg;
  logic [7:0] ep_reg [NUM_EP];
  rx_state_type rx_state_reg;
  logic [7:0] pid_reg;
  logic [BYTE_COUNT_W:0] byte_cnt_reg;
  logic [15:0] turn_cnt_reg;
  logic turn_wait_reg;
  reg_word_type err_set;
  logic overrun_evt;
  logic turn_evt;
  logic is_token;
  logic is_data;
  logic eop_pid_ok;
  logic wr_flags;
  logic ep_hit;
  logic [7:0] ep_idx;

  crc_feed_if feed ();

  usb_crc_checker u_crc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .feed(feed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive path: pid check, truncation, crc feed
  assign is_token = (pid_reg[1:0] == 2'b01);
  assign is_data = (pid_reg[1:0] == 2'b11);
  assign eop_pid_ok = (pid_reg[3:0] == ~pid_reg[7:4]);
  assign feed.clear = rx_pkt_start;
  assign feed.byte_valid = rx_byte_valid && (rx_state_reg == RX_BODY);
  assign feed.data = rx_byte;
  assign overrun_evt = feed.byte_valid && (byte_cnt_reg >= {1'b0, bd_byte_count});

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state_reg <= RX_IDLE;
    end else begin
      case (rx_state_reg)
        RX_IDLE: if (rx_pkt_start) rx_state_reg <= RX_PID;
        RX_PID: begin
          if (rx_eop) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_byte_valid) begin
            rx_state_reg <= RX_BODY;
          end
        end
        RX_BODY: if (rx_eop) rx_state_reg <= RX_IDLE;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pid_reg <= 8'h00;
    end else if (rx_state_reg == RX_PID && rx_byte_valid) begin
      pid_reg <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_cnt_reg <= '0;
      store_valid <= 1'b0;
      store_data <= 8'h00;
    end else begin
      store_valid <= feed.byte_valid && !overrun_evt;
      if (rx_pkt_start) begin
        byte_cnt_reg <= '0;
      end else if (feed.byte_valid && !overrun_evt) begin
        byte_cnt_reg <= byte_cnt_reg + 1'b1;
      end
      if (feed.byte_valid) begin
        store_data <= rx_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus turnaround timer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      turn_wait_reg <= 1'b0;
      turn_cnt_reg <= 16'h0000;
    end else if (resp_wait_start) begin
      turn_wait_reg <= 1'b1;
      turn_cnt_reg <= 16'h0000;
    end else if (resp_arrived || turn_evt) begin
      turn_wait_reg <= 1'b0;
    end else if (turn_wait_reg) begin
      turn_cnt_reg <= turn_cnt_reg + 16'h0001;
    end
  end
  assign turn_evt = turn_wait_reg && !resp_arrived && (turn_cnt_reg == 16'(TURN_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // error events and flags
  always_comb begin
    err_set = `RESET_WORD;
    err_set[`ERR_STUFF_BIT] = stuff_violation;
    err_set[`ERR_OVERRUN_BIT] = overrun_evt;
    err_set[`ERR_TURN_BIT] = turn_evt;
    if (rx_eop && rx_state_reg == RX_BODY) begin
      err_set[`ERR_PARTIAL_BIT] = (rx_bit_rem != 3'b000);
      err_set[`ERR_DCRC_BIT] = is_data && (feed.crc16 != `CRC16_GOOD);
      err_set[`ERR_PID_BIT] = !eop_pid_ok;
      err_set[`ERR_TCRC_BIT] = !mode_reg && is_token && (feed.crc5 != `CRC5_GOOD);
    end
    if (mode_reg) begin
      err_set[`ERR_TCRC_BIT] = frame_end_violation;
    end
  end

  assign wr_flags = reg_wr && (reg_addr == `ADDR_ERR_FLAGS);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_flags_reg <= `RESET_WORD;
    end else begin
      err_flags_reg <= ((err_flags_reg & ~(wr_flags ? reg_wdata : `RESET_WORD)) | err_set) & `ERR_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      token_accept <= 1'b0;
    end else begin
      token_accept <= rx_eop && rx_state_reg == RX_BODY && !mode_reg && is_token && eop_pid_ok
                      && (feed.crc5 == `CRC5_GOOD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables, mode, summary
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_enables_reg <= `RESET_WORD;
      mode_reg <= 1'b0;
      pwm_ctrl_reg <= `RESET_WORD;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_ERR_ENABLES) err_enables_reg <= reg_wdata & `ERR_IMPL_MASK;
      if (reg_addr == `ADDR_MODE_CTRL) mode_reg <= reg_wdata[`MODE_HOST_BIT];
      if (reg_addr == `ADDR_PWM_CTRL) pwm_ctrl_reg <= reg_wdata & `PWM_IMPL_MASK;
    end
  end

  // bit 1 of both registers shares one meaning chosen by mode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      summary_error_irq_flag <= 1'b0;
    end else begin
      summary_error_irq_flag <= |(err_flags_reg & err_enables_reg);
    end
  end
  assign host_mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // endpoint control registers
  assign ep_hit = (reg_addr >= `ADDR_EP_BASE) && (reg_addr < 8'(`ADDR_EP_BASE + NUM_EP));
  assign ep_idx = reg_addr - `ADDR_EP_BASE;

  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    localparam logic [7:0] MASK = (n == 0) ? `EP0_IMPL_MASK : `EPN_IMPL_MASK;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        ep_reg[n] <= 8'h00;
      end else begin
        if (reg_wr && ep_hit && ep_idx == 8'(n)) begin
          ep_reg[n] <= reg_wdata[7:0] & MASK;
        end
        if (ep_stall_event[n]) begin
          ep_reg[n][`EP_STALL_BIT] <= 1'b1;
        end
      end
    end
    assign ep_receive_active[n] = ep_reg[n][`EP_RX_BIT];
    assign ep_transmit_active[n] = ep_reg[n][`EP_TX_BIT];
    assign ep_setup_allowed[n] = ep_reg[n][`EP_RX_BIT] && ep_reg[n][`EP_TX_BIT]
                                 && !ep_reg[n][`EP_SETUPBLK_BIT];
    assign ep_handshake_active[n] = ep_reg[n][`EP_HSHK_BIT];
  end

  assign nak_retry_auto = mode_reg && !ep_reg[0][`EP_RETRYOFF_BIT];
  assign low_speed_direct = mode_reg && ep_reg[0][`EP_LOWSPD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // vbus pwm output stage
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vbus_pwm_out <= 1'b0;
    end else if (!pwm_ctrl_reg[`PWM_EN_BIT]) begin
      vbus_pwm_out <= pwm_ctrl_reg[`PWM_POL_BIT];
    end else begin
      vbus_pwm_out <= pwm_raw ^ pwm_ctrl_reg[`PWM_POL_BIT];
    end
  end
  assign vbus_counter_run = pwm_ctrl_reg[`PWM_CNT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_ERR_FLAGS) begin
        reg_rdata <= err_flags_reg;
      end else if (reg_addr == `ADDR_ERR_ENABLES) begin
        reg_rdata <= err_enables_reg;
      end else if (reg_addr == `ADDR_PWM_CTRL) begin
        reg_rdata <= pwm_ctrl_reg;
      end else if (reg_addr == `ADDR_MODE_CTRL) begin
        reg_rdata <= {15'h0000, mode_reg};
      end else if (ep_hit) begin
        reg_rdata <= {8'h00, ep_reg[ep_idx[3:0]]};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_stuff_seen;
    stuff_violation;
  endsequence

  chk_stuff_flag_set: assert property (s_stuff_seen |=> err_flags_reg[`ERR_STUFF_BIT])
    else $error("stuff flag not set after violation");

  chk_flag_w1c: assert property (wr_flags && !stuff_violation && reg_wdata[`ERR_STUFF_BIT]
    |=> !err_flags_reg[`ERR_STUFF_BIT])
    else $error("stuff flag not cleared by write of one");

  chk_flag_hold: assert property (wr_flags && !reg_wdata[`ERR_PID_BIT] && err_flags_reg[`ERR_PID_BIT]
    |=> err_flags_reg[`ERR_PID_BIT])
    else $error("flag lost on write of zero");

  chk_unimpl_zero: assert property ((err_flags_reg & ~`ERR_IMPL_MASK) == 16'h0000
    && (err_enables_reg & ~`ERR_IMPL_MASK) == 16'h0000)
    else $error("unimplemented error bits set");

  chk_summary_irq: assert property (##1 summary_error_irq_flag == |($past(err_flags_reg) & $past(err_enables_reg)))
    else $error("summary flag does not follow enabled flags");

  chk_turn_timeout: assert property (resp_wait_start ##1 (!resp_arrived && !resp_wait_start) [*8]
    |-> !err_flags_reg[`ERR_TURN_BIT] || $past(err_flags_reg[`ERR_TURN_BIT], 9) || TURN_CYCLES <= 8)
    else $error("turnaround timeout raised early");

  chk_retry_ep0: assert property (mode_reg && ep_reg[0][`EP_RETRYOFF_BIT] |-> !nak_retry_auto)
    else $error("nak retry active while disabled");

  chk_setup_gate: assert property (!(ep_reg[0][`EP_RX_BIT] && ep_reg[0][`EP_TX_BIT]) |-> !ep_setup_allowed[0])
    else $error("setup allowed without both directions");

  chk_pwm_idle: assert property (!pwm_ctrl_reg[`PWM_EN_BIT] ##1 !pwm_ctrl_reg[`PWM_EN_BIT]
    |-> vbus_pwm_out == $past(pwm_ctrl_reg[`PWM_POL_BIT]))
    else $error("pwm output not at reset level while disabled");

  chk_truncate: assert property (overrun_evt |=> !store_valid && err_flags_reg[`ERR_OVERRUN_BIT])
    else $error("excess byte stored or overrun not flagged");
endmodule : usb_error_endpoint_vbus_ctrl

// ===== sim/usb_bus_model.sv
// behavioural far side of the usb link: packets and line events
`timescale 1ns/1ps
module usb_bus_model (
  input wire logic ref_clk,
  output logic rx_pkt_start,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_eop,
  output logic [2:0] rx_bit_rem,
  output logic stuff_violation,
  output logic frame_end_violation,
  output logic resp_arrived
);
  initial begin
    {rx_pkt_start, rx_byte_valid, rx_eop, stuff_violation, frame_end_violation, resp_arrived} = '0;
    rx_byte = 8'h00;
    rx_bit_rem = 3'h0;
  end
  // gap idles between bytes model a slow sender; idle data is inverted each cycle
  task automatic send_packet(input logic [7:0] b[$], input logic [2:0] rem, input int gap);
    @(posedge ref_clk);
    rx_pkt_start <= 1'b1;
    foreach (b[i]) begin
      @(posedge ref_clk);
      rx_pkt_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= b[i];
      repeat (gap) begin
        @(posedge ref_clk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end
    end
    @(posedge ref_clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_eop <= 1'b1;
    rx_bit_rem <= rem;
    @(posedge ref_clk);
    rx_eop <= 1'b0;
    rx_bit_rem <= 3'h0;
  endtask : send_packet
  task automatic line_event(input logic stuff, input logic eof, input logic resp);
    @(posedge ref_clk);
    {stuff_violation, frame_end_violation, resp_arrived} <= {stuff, eof, resp};
    @(posedge ref_clk);
    {stuff_violation, frame_end_violation, resp_arrived} <= 3'h0;
  endtask : line_event
endmodule : usb_bus_model

// ===== sim/usb_error_endpoint_vbus_ctrl_bench.sv
// self-checking bench for the usb error, endpoint and vbus control block
`timescale 1ns/1ps
`include "usb_err_consts.svh"
module usb_error_endpoint_vbus_ctrl_bench;
  import usb_err_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  reg_word_type reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, resp_wait_start = 1'b0, pwm_raw = 1'b0;
  logic [9:0] bd_byte_count = 10'h040;
  logic [15:0] ep_stall_event = 16'h0000;
  reg_word_type reg_rdata, d;
  logic rx_pkt_start, rx_byte_valid, rx_eop, stuff_violation, frame_end_violation, resp_arrived;
  logic [7:0] rx_byte, store_data, last_store;
  logic [2:0] rx_bit_rem;
  logic store_valid, token_accept, summary_error_irq_flag, host_mode, nak_retry_auto, low_speed_direct;
  logic vbus_pwm_out, vbus_counter_run, raw;
  logic [15:0] ep_receive_active, ep_transmit_active, ep_setup_allowed, ep_handshake_active;
  reg_word_type ep_val [16];
  logic [7:0] q [$];
  int n_errors = 0, tests_run = 0, n_store = 0, n_token = 0, ns, seed = 46;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_store <= n_store + int'(store_valid === 1'b1);
    n_token <= n_token + int'(token_accept === 1'b1);
    if (store_valid === 1'b1) last_store <= store_data;
  end

  usb_error_endpoint_vbus_ctrl usb_error_endpoint_vbus_ctrl_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pkt_start(rx_pkt_start), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_eop(rx_eop), .rx_bit_rem(rx_bit_rem), .stuff_violation(stuff_violation),
    .frame_end_violation(frame_end_violation), .bd_byte_count(bd_byte_count),
    .resp_wait_start(resp_wait_start), .resp_arrived(resp_arrived), .ep_stall_event(ep_stall_event),
    .pwm_raw(pwm_raw), .store_valid(store_valid), .store_data(store_data), .token_accept(token_accept),
    .summary_error_irq_flag(summary_error_irq_flag), .host_mode(host_mode),
    .ep_receive_active(ep_receive_active), .ep_transmit_active(ep_transmit_active),
    .ep_setup_allowed(ep_setup_allowed), .ep_handshake_active(ep_handshake_active),
    .nak_retry_auto(nak_retry_auto), .low_speed_direct(low_speed_direct), .vbus_pwm_out(vbus_pwm_out),
    .vbus_counter_run(vbus_counter_run));
  usb_bus_model usb_bus_model_i (
    .ref_clk(ref_clk), .rx_pkt_start(rx_pkt_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_eop(rx_eop), .rx_bit_rem(rx_bit_rem), .stuff_violation(stuff_violation),
    .frame_end_violation(frame_end_violation), .resp_arrived(resp_arrived));

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input reg_word_type v);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // reads flags through a mask, then clears them all
  task automatic flags_are(input reg_word_type m, input reg_word_type e);
    repeat (2) @(posedge ref_clk);
    rd(`ADDR_ERR_FLAGS);
    check(d & m, e);
    wr(`ADDR_ERR_FLAGS, 16'hFFFF);
  endtask : flags_are
  function automatic reg_word_type impl_mask(input logic [7:0] a);
    case (a)
      `ADDR_ERR_ENABLES: return `ERR_IMPL_MASK;
      `ADDR_PWM_CTRL: return `PWM_IMPL_MASK;
      `ADDR_MODE_CTRL: return 16'h0001;
      `ADDR_EP_BASE: return {8'h00, `EP0_IMPL_MASK};
      default: return (a > `ADDR_EP_BASE && a < 8'h20) ? {8'h00, `EPN_IMPL_MASK} : 16'h0000;
    endcase
  endfunction : impl_mask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 32; a++) begin
      rd(8'(a));
      check(d, 16'h0000);
    end
    for (int a = 1; a < 32; a++) begin
      wr(8'(a), 16'($random(seed)));
      rd(8'(a));
      check(d, reg_wdata & impl_mask(8'(a)));
      if (a >= 16) ep_val[a-16] = reg_wdata & impl_mask(8'(a));
    end
    for (int n = 0; n < 16; n++) begin
      d = ep_val[n];
      check({ep_receive_active[n], ep_transmit_active[n], ep_setup_allowed[n], ep_handshake_active[n]},
            {d[3], d[2], d[3] & d[2] & ~d[4], d[0]});
    end
    wr(`ADDR_MODE_CTRL, 16'h0001);
    wr(`ADDR_EP_BASE, 16'h0040);
    #1 check({host_mode, nak_retry_auto, low_speed_direct}, 3'h4);
    wr(`ADDR_EP_BASE, 16'h0080);
    #1 check({host_mode, nak_retry_auto, low_speed_direct}, 3'h7);
    wr(`ADDR_ERR_ENABLES, 16'h0000);
    wr(`ADDR_ERR_FLAGS, 16'hFFFF);
    usb_bus_model_i.line_event(1'b0, 1'b1, 1'b0);
    flags_are(16'hFFFF, 16'h0002);
    wr(`ADDR_ERR_ENABLES, 16'h0002);
    usb_bus_model_i.line_event(1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge ref_clk);
    check(summary_error_irq_flag, 1'b1);
    wr(`ADDR_ERR_ENABLES, 16'h0080);
    repeat (3) @(posedge ref_clk);
    check(summary_error_irq_flag, 1'b0);
    wr(`ADDR_MODE_CTRL, 16'h0000);
    wr(`ADDR_ERR_FLAGS, 16'hFFFF);
    check({host_mode, nak_retry_auto, low_speed_direct}, 3'h0);
    usb_bus_model_i.line_event(1'b0, 1'b1, 1'b0);
    flags_are(16'hFFFF, 16'h0000);
    usb_bus_model_i.line_event(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    check(summary_error_irq_flag, 1'b1);
    wr(`ADDR_ERR_FLAGS, 16'h0000);
    wr(`ADDR_ERR_FLAGS, 16'h0001);
    rd(`ADDR_ERR_FLAGS);
    check(d, 16'h0080);
    flags_are(16'hFFFF, 16'h0080);
    ns = n_token;
    usb_bus_model_i.send_packet('{8'h2D, 8'h00, 8'h10}, 3'h0, 0);
    flags_are(16'hFFFF, 16'h0000);
    usb_bus_model_i.send_packet('{8'h2D, 8'h00, 8'h11}, 3'h0, 1);
    flags_are(16'hFFFF, 16'h0002);
    check(16'(n_token - ns), 16'h0001);
    usb_bus_model_i.send_packet('{8'h2C, 8'h00, 8'h10}, 3'h0, 0);
    flags_are(16'h0001, 16'h0001);
    usb_bus_model_i.send_packet('{8'hC3, 8'h00, 8'h00}, 3'h0, 0);
    flags_are(16'hFFFF, 16'h0000);
    usb_bus_model_i.send_packet('{8'hC3, 8'h00, 8'h01}, 3'h0, 2);
    flags_are(16'hFFFF, 16'h0004);
    usb_bus_model_i.send_packet('{8'hC3, 8'h00, 8'h00}, 3'h3, 0);
    flags_are(16'hFFFF, 16'h0008);
    bd_byte_count <= 10'h002;
    q = '{8'hC3};
    repeat (4) q.push_back(8'($random(seed)));
    ns = n_store;
    usb_bus_model_i.send_packet(q, 3'h0, 1);
    flags_are(16'h0020, 16'h0020);
    check(16'(n_store - ns), 16'h0002);
    check(last_store, q[2]);
    bd_byte_count <= 10'h040;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      resp_wait_start <= 1'b1;
      @(posedge ref_clk);
      resp_wait_start <= 1'b0;
      if (i == 1) usb_bus_model_i.line_event(1'b0, 1'b0, 1'b1);
      repeat (78) @(posedge ref_clk);
      flags_are(16'hFFFF, i == 0 ? 16'h0010 : 16'h0000);
    end
    repeat (4) begin
      ns = {$random(seed)} % 16;
      wr(8'(`ADDR_EP_BASE + ns), 16'h0000);
      rd(8'(`ADDR_EP_BASE + ns));
      check(d[1], 1'b0);
      @(posedge ref_clk);
      ep_stall_event <= 16'h0001 << ns;
      @(posedge ref_clk);
      ep_stall_event <= 16'h0000;
      rd(8'(`ADDR_EP_BASE + ns));
      check(d[1], 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      raw = 1'($random(seed));
      wr(`ADDR_PWM_CTRL, {i[2], 5'h00, i[1], i[0], 8'h00});
      pwm_raw <= raw;
      repeat (3) @(posedge ref_clk);
      #1 check({vbus_pwm_out, vbus_counter_run}, {i[2] ? raw ^ i[1] : i[1], i[0]});
    end
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule : usb_error_endpoint_vbus_ctrl_bench
